//--- common/perf_pkg.sv
// constants and types shared by the dual event performance counter
package perf_pkg;
  localparam int MSR_ADDR_W = 32;
  localparam int MSR_DATA_W = 64;
  localparam int CTRL_W = 32;
  localparam int EVT_W = 6;
  localparam int CC_W = 3;
  localparam int CTR_W = 40;
  localparam int NUM_CTR = 2;

  // model register indices of this block
  localparam logic [MSR_ADDR_W-1:0] IDX_CTRL = 32'h0000_0011;
  localparam logic [MSR_ADDR_W-1:0] IDX_CTR_A = 32'h0000_0012;
  localparam logic [MSR_ADDR_W-1:0] IDX_CTR_B = 32'h0000_0013;
  localparam logic [MSR_ADDR_W-1:0] IDX_STATUS = 32'h0000_0014;

  // field positions inside the control register
  localparam int EVT_A_LSB = 0;
  localparam int EVT_B_LSB = 16;
  localparam int CC_A_LSB = 6;
  localparam int CC_B_LSB = 22;
  localparam int PF_A_BIT = 9;
  localparam int PF_B_BIT = 25;
  localparam logic [CTRL_W-1:0] CTRL_MASK = 32'h03ff_03ff;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 32'h0000_0000;

  // bits of the count control code
  localparam int CC_SUPV_BIT = 0;
  localparam int CC_USER_BIT = 1;
  localparam int CC_DUR_BIT = 2;
  localparam logic [1:0] CPL_USER = 2'h3;

  localparam logic [CTR_W-1:0] CTR_RESET = 40'h00_0000_0000;
  localparam logic [1:0] EVT_MAX_STEP = 2'h2;

  // indicator pin lag behind the counter update, in clocks
  localparam int PIN_LAG_CLK = 5;
  localparam int PIN_PIPE_D = PIN_LAG_CLK - 1;
  localparam int SYNC_W = 3;

  typedef logic [CC_W-1:0] cc_t;
  typedef logic [EVT_W-1:0] evt_t;
  typedef logic [CTR_W-1:0] ctr_t;
endpackage

//--- common/ctr_if.sv
// carrier between the control logic and one counter slice
`timescale 1ns/1ps
interface ctr_if;
  import perf_pkg::*;
  cc_t cc;
  logic [1:0] current_privilege_level;
  logic [1:0] evt_inc;
  logic evt_active;
  logic load;
  ctr_t load_val;
  ctr_t value;
  logic incr;
  logic ovf_pulse;
  logic ovf_flag;
  modport slice (
    input cc, current_privilege_level, evt_inc, evt_active, load, load_val,
    output value, incr, ovf_pulse, ovf_flag
  );
  modport ctl (
    output cc, current_privilege_level, evt_inc, evt_active, load, load_val,
    input value, incr, ovf_pulse, ovf_flag
  );
endinterface

//--- hdl/perf_counter_slice.sv
// one 40-bit counter with privilege gating and sticky overflow
`timescale 1ns/1ps
module perf_counter_slice
  import perf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ctr_if.slice c
);
  ctr_t value_r, value_nxt;
  logic incr_r, incr_nxt;
  logic ovf_r, ovf_nxt;
  logic flag_r, flag_nxt;
  logic allow;
  logic [1:0] step;
  logic [CTR_W:0] sum;

  always_comb begin
    allow = (c.current_privilege_level == CPL_USER) ? c.cc[CC_USER_BIT] : c.cc[CC_SUPV_BIT];
    if (c.cc[CC_DUR_BIT]) begin
      step = c.evt_active ? 2'h1 : 2'h0;
    end else if (c.evt_inc > EVT_MAX_STEP) begin
      step = EVT_MAX_STEP;
    end else begin
      step = c.evt_inc;
    end
    // codes 000 and 100 have both gate bits clear
    if (!allow) begin
      step = 2'h0;
    end
    // add event count or one tick
    sum = {1'b0, value_r} + {{(CTR_W - 1){1'b0}}, step};
    value_nxt = sum[CTR_W-1:0];
    incr_nxt = (step != 2'h0);
    // carry out of bit 39 is overflow
    ovf_nxt = sum[CTR_W];
    // a write from software replaces this cycle's count
    if (c.load) begin
      value_nxt = c.load_val;
      incr_nxt = 1'b0;
      ovf_nxt = 1'b0;
    end
    // sticky flag, clear wins over set since a write also zeroes the overflow
    flag_nxt = ovf_nxt | (flag_r & ~c.load);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      value_r <= CTR_RESET;
      incr_r <= 1'b0;
      ovf_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      value_r <= value_nxt;
      incr_r <= incr_nxt;
      ovf_r <= ovf_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign c.value = value_r;
  assign c.incr = incr_r;
  assign c.ovf_pulse = ovf_r;
  assign c.ovf_flag = flag_r;
endmodule

//--- hdl/dual_event_perf_counter.sv
// dual event performance counter: control register, model register port, indicator pins
`timescale 1ns/1ps
module dual_event_perf_counter
  import perf_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic MSR_RD_EN,
  input wire logic MSR_WR_EN,
  input wire logic [MSR_ADDR_W-1:0] MSR_ADDR,
  input wire logic [MSR_DATA_W-1:0] MSR_WDATA,
  output logic [MSR_DATA_W-1:0] MSR_RDATA,
  output logic MSR_RDATA_VALID,
  output logic MSR_ADDR_ERR,
  input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
  input wire logic [1:0] EVENT_INC_A,
  input wire logic EVENT_ACTIVE_A,
  input wire logic [1:0] EVENT_INC_B,
  input wire logic EVENT_ACTIVE_B,
  output logic [EVT_W-1:0] EVENT_CODE_A,
  output logic [EVT_W-1:0] EVENT_CODE_B,
  input wire logic BP_MODE_REQ,
  input wire logic BP_MATCH_A,
  input wire logic BP_MATCH_B,
  output logic INDICATOR_PIN_A,
  output logic INDICATOR_PIN_B,
  output logic OVF_FLAG_A,
  output logic OVF_FLAG_B
);
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [MSR_DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic err_r, err_nxt;
  logic [SYNC_W-1:0] sync1_r, sync1_nxt;
  logic [SYNC_W-1:0] sync2_r, sync2_nxt;
  logic [PIN_PIPE_D-1:0] pipe_r [NUM_CTR];
  logic [PIN_PIPE_D-1:0] pipe_nxt [NUM_CTR];
  logic [NUM_CTR-1:0] pin_r, pin_nxt;
  logic [NUM_CTR-1:0] pin_src;
  logic [NUM_CTR-1:0] pin_flag;
  logic [NUM_CTR-1:0] ovf_flag;
  logic [NUM_CTR-1:0] load;
  ctr_t ctr_val [NUM_CTR];
  logic bp_mode;
  logic [NUM_CTR-1:0] bp_match;
  logic wr_ctrl;
  logic mapped;

  ctr_if cif [NUM_CTR] ();

  function automatic cc_t cc_of(input logic [CTRL_W-1:0] c, input int k);
    return (k == 0) ? c[CC_A_LSB +: CC_W] : c[CC_B_LSB +: CC_W];
  endfunction

  // address decode for the model register port
  always_comb begin
    wr_ctrl = MSR_WR_EN && (MSR_ADDR == IDX_CTRL);
    load[0] = MSR_WR_EN && (MSR_ADDR == IDX_CTR_A);
    load[1] = MSR_WR_EN && (MSR_ADDR == IDX_CTR_B);
    mapped = (MSR_ADDR == IDX_CTRL) || (MSR_ADDR == IDX_CTR_A) ||
             (MSR_ADDR == IDX_CTR_B) || (MSR_ADDR == IDX_STATUS);
  end

  // control register
  always_comb begin
    ctrl_nxt = ctrl_r;
    // whole-register write only; reserved bits are not stored
    if (wr_ctrl) begin
      ctrl_nxt = MSR_WDATA[CTRL_W-1:0] & CTRL_MASK;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // event codes out to the event logic
  assign EVENT_CODE_A = ctrl_r[EVT_A_LSB +: EVT_W];
  assign EVENT_CODE_B = ctrl_r[EVT_B_LSB +: EVT_W];

  assign pin_flag[0] = ctrl_r[PF_A_BIT];
  assign pin_flag[1] = ctrl_r[PF_B_BIT];

  // counter slices
  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : gen_ctr
      // control code routed to each slice
      assign cif[g].cc = cc_of(ctrl_r, g);
      assign cif[g].current_privilege_level = CURRENT_PRIVILEGE_LEVEL;
      assign cif[g].evt_inc = (g == 0) ? EVENT_INC_A : EVENT_INC_B;
      assign cif[g].evt_active = (g == 0) ? EVENT_ACTIVE_A : EVENT_ACTIVE_B;
      // preload from the low data bits
      assign cif[g].load = load[g];
      assign cif[g].load_val = MSR_WDATA[CTR_W-1:0];
      assign ctr_val[g] = cif[g].value;
      assign ovf_flag[g] = cif[g].ovf_flag;
      // one increment flag per clock, whatever the step
      assign pin_src[g] = pin_flag[g] ? cif[g].ovf_pulse : cif[g].incr;

      perf_counter_slice u_slice (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .c(cif[g])
      );
    end
  endgenerate

  // read path, answered one clock after the request
  always_comb begin
    rdata_nxt = '0;
    rvalid_nxt = 1'b0;
    err_nxt = 1'b0;
    if (MSR_RD_EN) begin
      rvalid_nxt = 1'b1;
      // live sample, counting is not held off
      case (MSR_ADDR)
        IDX_CTRL: rdata_nxt = MSR_DATA_W'(ctrl_r);
        IDX_CTR_A: rdata_nxt = MSR_DATA_W'(ctr_val[0]);
        IDX_CTR_B: rdata_nxt = MSR_DATA_W'(ctr_val[1]);
        IDX_STATUS: rdata_nxt = MSR_DATA_W'(ovf_flag);
        default: err_nxt = 1'b1;
      endcase
    end
    // writes to unmapped or read-only indices are dropped but flagged
    if (MSR_WR_EN && (!mapped || (MSR_ADDR == IDX_STATUS))) begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r <= err_nxt;
    end
  end

  assign MSR_RDATA = rdata_r;
  assign MSR_RDATA_VALID = rvalid_r;
  assign MSR_ADDR_ERR = err_r;

  // debugger inputs come from outside, two flops before use
  always_comb begin
    sync1_nxt = {BP_MATCH_B, BP_MATCH_A, BP_MODE_REQ};
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign bp_mode = sync2_r[0];
  assign bp_match = sync2_r[2:1];

  // pin pipeline; keeps running in breakpoint mode so a switch back
  // shows only fresh activity after the lag
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      pipe_nxt[i] = {pipe_r[i][PIN_PIPE_D-2:0], pin_src[i]};
      // breakpoint match takes the pin over
      pin_nxt[i] = bp_mode ? bp_match[i] : pipe_r[i][PIN_PIPE_D-1];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NUM_CTR; i++) begin
        pipe_r[i] <= '0;
      end
      pin_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        pipe_r[i] <= pipe_nxt[i];
      end
      pin_r <= pin_nxt;
    end
  end

  assign INDICATOR_PIN_A = pin_r[0];
  assign INDICATOR_PIN_B = pin_r[1];
  assign OVF_FLAG_A = ovf_flag[0];
  assign OVF_FLAG_B = ovf_flag[1];
endmodule

//--- tb/perf_chk.sv
// port assertions for the dual event performance counter
`timescale 1ns/1ps
module perf_chk
  import perf_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic MSR_WR_EN,
  input wire logic [MSR_ADDR_W-1:0] MSR_ADDR,
  input wire logic [MSR_DATA_W-1:0] MSR_WDATA,
  input wire logic [1:0] EVENT_INC_A,
  input wire logic EVENT_ACTIVE_A,
  input wire logic [EVT_W-1:0] EVENT_CODE_A,
  input wire logic BP_MODE_REQ,
  input wire logic BP_MATCH_A,
  input wire logic INDICATOR_PIN_A,
  input wire logic OVF_FLAG_A
);
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic wr_ctr_a;
  cc_t cc_a;
  logic pf_a;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  assign wr_ctr_a = MSR_WR_EN && MSR_ADDR == IDX_CTR_A;
  assign cc_a = ctrl_r[8:6];
  assign pf_a = ctrl_r[PF_A_BIT];
  // mirror of the control register, needed to know the pin mode
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (SYS_RST) begin
      ctrl_nxt = CTRL_RESET;
    end else if (MSR_WR_EN && MSR_ADDR == IDX_CTRL) begin
      ctrl_nxt = MSR_WDATA[31:0] & CTRL_MASK;
    end
  end
  always_ff @(posedge REF_CLK) begin
    ctrl_r <= ctrl_nxt;
  end
  sequence s_inc_a;
    cc_a[1:0] == 2'h3 && !pf_a && !BP_MODE_REQ && !wr_ctr_a &&
      (cc_a[2] ? EVENT_ACTIVE_A : EVENT_INC_A != 2'h0);
  endsequence
  sequence s_ovf_a;
    ($rose(OVF_FLAG_A) && pf_a) ##1 (pf_a && !BP_MODE_REQ)[*4];
  endsequence
  property p_code; MSR_WR_EN && MSR_ADDR == IDX_CTRL |=> EVENT_CODE_A == ctrl_r[5:0]; endproperty
  property p_rst; $fell(SYS_RST) |-> EVENT_CODE_A == 6'h0 && !OVF_FLAG_A; endproperty
  property p_off; (cc_a[1:0] == 2'h0 && !BP_MODE_REQ)[*8] |-> !INDICATOR_PIN_A; endproperty
  // pin register is seen one edge after the five-stage lag
  property p_inc; s_inc_a ##1 (!BP_MODE_REQ)[*6] |-> INDICATOR_PIN_A; endproperty
  property p_ovm; (pf_a && !OVF_FLAG_A && !BP_MODE_REQ)[*7] |-> !INDICATOR_PIN_A; endproperty
  property p_ovp; s_ovf_a |=> INDICATOR_PIN_A; endproperty
  property p_flag; OVF_FLAG_A && !wr_ctr_a |=> OVF_FLAG_A; endproperty
  property p_bp; (BP_MODE_REQ && BP_MATCH_A)[*4] |-> INDICATOR_PIN_A; endproperty
  a_code: assert property (p_code) else $error("event code a off");
  a_rst: assert property (p_rst) else $error("state after reset off");
  a_off: assert property (p_off) else $error("disabled pin active");
  a_inc: assert property (p_inc) else $error("increment pin missing");
  a_ovm: assert property (p_ovm) else $error("pin early in ovf mode");
  a_ovp: assert property (p_ovp) else $error("ovf pin late");
  a_flag: assert property (p_flag) else $error("ovf flag lost");
  a_bp: assert property (p_bp) else $error("match pin missing");
endmodule
bind dual_event_perf_counter perf_chk u_perf_chk (.REF_CLK, .SYS_RST, .MSR_WR_EN,
  .MSR_ADDR, .MSR_WDATA, .EVENT_INC_A, .EVENT_ACTIVE_A, .EVENT_CODE_A,
  .BP_MODE_REQ, .BP_MATCH_A, .INDICATOR_PIN_A, .OVF_FLAG_A);

//--- tb/pin_monitor.sv
// outside monitor counting high clocks on the indicator pins
`timescale 1ns/1ps
module pin_monitor (
  input wire logic clk,
  input wire logic pin_a,
  input wire logic pin_b,
  output int high_a,
  output int high_b
);
  initial begin
    high_a = 0;
    high_b = 0;
  end
  // pins only sampled on the clock, callers allow for lag
  always @(posedge clk) begin
    high_a <= high_a + int'(pin_a === 1'b1);
    high_b <= high_b + int'(pin_b === 1'b1);
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the dual event performance counter
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench
  import perf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [MSR_ADDR_W-1:0] addr = '0;
  logic [MSR_DATA_W-1:0] wdata = '0;
  logic [MSR_DATA_W-1:0] rdata;
  logic rvalid;
  logic err;
  logic [1:0] current_privilege_level = 2'h0;
  logic [1:0] inc_a = 2'h0;
  logic [1:0] inc_b = 2'h0;
  logic act_a = 1'b0;
  logic act_b = 1'b0;
  logic bp_mode = 1'b0;
  logic bp_a = 1'b0;
  logic pin_a;
  logic pin_b;
  logic ovf_a;
  logic [EVT_W-1:0] code_b;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int high_a;
  int high_b;
  always #2 clk = ~clk;
  dual_event_perf_counter u_dual_event_perf_counter (.REF_CLK(clk), .SYS_RST(rst),
    .MSR_RD_EN(rd), .MSR_WR_EN(wr), .MSR_ADDR(addr), .MSR_WDATA(wdata),
    .MSR_RDATA(rdata), .MSR_RDATA_VALID(rvalid), .MSR_ADDR_ERR(err), .CURRENT_PRIVILEGE_LEVEL(current_privilege_level),
    .EVENT_INC_A(inc_a), .EVENT_ACTIVE_A(act_a), .EVENT_INC_B(inc_b),
    .EVENT_ACTIVE_B(act_b), .EVENT_CODE_A(), .EVENT_CODE_B(code_b),
    .BP_MODE_REQ(bp_mode), .BP_MATCH_A(bp_a), .BP_MATCH_B(1'b0),
    .INDICATOR_PIN_A(pin_a), .INDICATOR_PIN_B(pin_b), .OVF_FLAG_A(ovf_a), .OVF_FLAG_B());
  pin_monitor u_pin_monitor (.clk(clk), .pin_a(pin_a), .pin_b(pin_b),
    .high_a(high_a), .high_b(high_b));
  task automatic complete_run;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [MSR_ADDR_W-1:0] a, input logic [MSR_DATA_W-1:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [MSR_ADDR_W-1:0] a, input logic [MSR_DATA_W-1:0] e);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    `CHK("read valid", 1'b1, rvalid)
    `CHK("read data", e, rdata)
    @(negedge clk);
  endtask
  task automatic t_fields;
    rd_chk(IDX_CTRL, 64'h0);
    wr_reg(IDX_CTRL, {32'h0, 32'hffff_ffff});
    rd_chk(IDX_CTRL, 64'h03ff_03ff);
    // status index is read-only, write refused
    wr = 1'b1;
    addr = IDX_STATUS;
    wdata = 64'h3;
    @(negedge clk);
    wr = 1'b0;
    `CHK("addr err", 1'b1, err)
    @(negedge clk);
    `CHK("addr err clear", 1'b0, err)
    rd_chk(IDX_STATUS, 64'h0);
  endtask
  task automatic t_codes;
    logic gate;
    logic [2:0] cc;
    logic [39:0] e;
    int n_a;
    int n_b;
    for (int p = 0; p < 4; p += 3) begin
      for (int c = 0; c < 8; c++) begin
        cc = c[2:0];
        current_privilege_level = p[1:0];
        // whole control word written each time
        wr_reg(IDX_CTRL, {32'h0, 7'h0, cc, 6'h15, 7'h0, cc, 6'h2a});
        `CHK("code b", 6'h15, code_b)
        wr_reg(IDX_CTR_A, 64'h0);
        wr_reg(IDX_CTR_B, 64'h0);
        n_a = high_a;
        n_b = high_b;
        inc_a = 2'h2;
        inc_b = 2'h3;
        act_a = 1'b1;
        act_b = 1'b1;
        repeat (4) @(negedge clk);
        inc_a = 2'h0;
        inc_b = 2'h0;
        act_a = 1'b0;
        act_b = 1'b0;
        repeat (7) @(negedge clk);
        gate = (p == 3) ? cc[1] : cc[0];
        e = !gate ? 40'h0 : (cc[2] ? 40'h4 : 40'h8);
        rd_chk(IDX_CTR_A, {24'h0, e});
        rd_chk(IDX_CTR_B, {24'h0, e});
        `CHK("pin highs a", gate ? 4 : 0, high_a - n_a)
        `CHK("pin highs b", gate ? 4 : 0, high_b - n_b)
      end
    end
  endtask
  task automatic t_ovf;
    int n;
    wr_reg(IDX_CTRL, 64'h2c0);
    // two below the wrap, third event leaves one
    wr_reg(IDX_CTR_A, 64'hff_ffff_fffe);
    n = high_a;
    inc_a = 2'h1;
    repeat (3) @(negedge clk);
    inc_a = 2'h0;
    repeat (7) @(negedge clk);
    rd_chk(IDX_CTR_A, 64'h1);
    rd_chk(IDX_STATUS, 64'h1);
    `CHK("ovf pin highs", 1, high_a - n)
    wr_reg(IDX_CTR_A, 64'h0);
    `CHK("ovf flag", 1'b0, ovf_a)
  endtask
  task automatic t_bp;
    bp_mode = 1'b1;
    bp_a = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("match pin a", 1'b1, pin_a)
    `CHK("match pin b", 1'b0, pin_b)
    bp_mode = 1'b0;
    bp_a = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("pin a back", 1'b0, pin_a)
  endtask
  // run is short, so a hang is cut well before it matters
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_fields();
    t_codes();
    t_ovf();
    t_bp();
    complete_run();
  end
endmodule
